// ==== core/fperr_pkg.sv ====
package fperr_pkg;

  // ---------------------------------------------------------------
  // exception classes
  // ---------------------------------------------------------------
  localparam int unsigned NUM_CLASSES = 6;
  localparam int unsigned EXC_INVALID = 0;
  localparam int unsigned EXC_DENORM  = 1;
  localparam int unsigned EXC_ZDIV    = 2;
  localparam int unsigned EXC_OVER    = 3;
  localparam int unsigned EXC_UNDER   = 4;
  localparam int unsigned EXC_INEXACT = 5;

  // ---------------------------------------------------------------
  // register map (APB byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CMD    = 8'h08;
  localparam logic [7:0] ADDR_STATE  = 8'h0C;

  // control field positions
  localparam int unsigned CTRL_MASK_LSB = 0;
  localparam int unsigned CTRL_RND_LSB  = 8;
  localparam int unsigned CTRL_NE_BIT   = 12;
  localparam int unsigned CTRL_IF_BIT   = 13;

  // status field positions
  localparam int unsigned STAT_SF_BIT   = 6;
  localparam int unsigned STAT_ERR_BIT  = 7;

  // command bits (write one to act)
  localparam int unsigned CMD_CLEAR   = 0;
  localparam int unsigned CMD_REINIT  = 1;
  localparam int unsigned CMD_SAVE    = 2;
  localparam int unsigned CMD_RESTORE = 3;
  localparam int unsigned CMD_LDENV   = 4;

  // reset values
  localparam logic [5:0] MASK_RESET = 6'h3F;
  localparam logic [1:0] RND_RESET  = 2'h0;

  // rounding choices
  typedef enum logic [1:0] {
    FPERR_RND_NEAREST = 2'b00,
    FPERR_RND_DOWN    = 2'b01,
    FPERR_RND_UP      = 2'b10,
    FPERR_RND_ZERO    = 2'b11
  } fperr_rnd_t;

  // instruction issue states
  typedef enum logic [1:0] {
    FPERR_RUN    = 2'b00,
    FPERR_FROZEN = 2'b01,
    FPERR_IRQ    = 2'b10
  } fperr_state_t;

endpackage : fperr_pkg

// ==== core/fperr_sync.sv ====
`timescale 1ns/100ps
`default_nettype none

// three-stage pin synchroniser; output changes when stages two and three agree
module fperr_sync (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic pin_in,
  output var  logic level_out
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // ---------------------------------------------------------------
  // capture chain
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // filter: only a level seen twice in a row is passed on
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      level_out <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_out <= s3_q;
    end
  end

endmodule : fperr_sync
`default_nettype wire

// ==== core/fperr_unit.sv ====
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module fperr_unit (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // apb slave
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic       pready,
  output var  logic       pslverr,
  // execution side
  input  wire logic       instr_valid,
  input  wire logic       instr_nowait,
  input  wire logic       instr_vector,
  input  wire logic [5:0] exc_detect,
  input  wire logic       exc_stack_fault,
  input  wire logic       tiny_result,
  input  wire logic       below_min_denorm,
  output var  logic       instr_stall,
  output var  logic       instr_abort,
  output var  logic       fixup_apply,
  output var  logic       result_denorm,
  output var  logic       result_zero,
  output var  logic [1:0] round_mode,
  output var  logic       vector_exc,
  output var  logic       handler_enter,
  // pins
  input  wire logic       ignore_numeric_error_in,
  input  wire logic       maskable_interrupt_in,
  output var  logic       fp_error_out
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [5:0]  mask_q;
  logic [1:0]  rnd_q;
  logic        native_error_enable_q;
  logic        if_flag_q;
  logic [5:0]  flags_q;
  logic        stack_fault_exc_q;
  logic        pending_q;
  logic        ignore_s;
  logic        maskable_interrupt_in_s;
  fperr_pkg::fperr_state_t state_q;
  logic [5:0]  unmasked;
  logic        wr_en;
  logic        rd_en;
  logic        cmd_clr;
  logic        ldenv_wr;
  logic        stall_now;

  // decode of an apb address against one register
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ref_a);
    addr_hit = (a == ref_a);
  endfunction : addr_hit

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // both pins come from board logic that runs on its own timing; the
  // filter costs three to four cycles, which the handler never notices
  fperr_sync u_sync_ign (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pin_in    (ignore_numeric_error_in),
    .level_out (ignore_s)
  );

  // interrupt request, gated by the flag only inside the freeze machine
  fperr_sync u_sync_int (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pin_in    (maskable_interrupt_in),
    .level_out (maskable_interrupt_in_s)
  );

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // writes act in the access cycle; reads are captured in setup so that
  // prdata already stands when pready is high
  assign wr_en    = psel && penable && pwrite;
  assign rd_en    = psel && !penable && !pwrite;
  assign cmd_clr  = wr_en && addr_hit(paddr, fperr_pkg::ADDR_CMD) &&
                    (pwdata[fperr_pkg::CMD_CLEAR] || pwdata[fperr_pkg::CMD_REINIT] ||
                     pwdata[fperr_pkg::CMD_SAVE]);
  // a status write is an environment load: it overwrites every flag and
  // the stack fault bit, whatever value the written word carries
  assign ldenv_wr = wr_en && addr_hit(paddr, fperr_pkg::ADDR_STATUS);

  // vector-extension exceptions bypass the legacy reporting path
  assign unmasked  = instr_vector ? 6'h00 : (exc_detect & ~mask_q);

  // ---------------------------------------------------------------
  // control register: masks, rounding, native enable, interrupt flag
  // ---------------------------------------------------------------
  // reinit restores masks and rounding; native enable and flag stay put
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_q                <= fperr_pkg::MASK_RESET;
      rnd_q                 <= fperr_pkg::RND_RESET;
      native_error_enable_q <= 1'b0;
      if_flag_q             <= 1'b0;
    end else if (wr_en && addr_hit(paddr, fperr_pkg::ADDR_CTRL)) begin
      mask_q                <= pwdata[fperr_pkg::CTRL_MASK_LSB +: 6];
      rnd_q                 <= pwdata[fperr_pkg::CTRL_RND_LSB +: 2];
      native_error_enable_q <= pwdata[fperr_pkg::CTRL_NE_BIT];
      if_flag_q             <= pwdata[fperr_pkg::CTRL_IF_BIT];
    end else if (wr_en && addr_hit(paddr, fperr_pkg::ADDR_CMD) &&
                 pwdata[fperr_pkg::CMD_REINIT]) begin
      mask_q <= fperr_pkg::MASK_RESET;
      rnd_q  <= fperr_pkg::RND_RESET;
    end
  end

  // ---------------------------------------------------------------
  // sticky exception flags; hardware set wins over a clear
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_q           <= 6'h00;
      stack_fault_exc_q <= 1'b0;
    end else begin
      // several classes can land in one instruction, all are kept
      if (ldenv_wr) begin
        flags_q           <= pwdata[5:0] | (instr_valid ? exc_detect : 6'h00);
        stack_fault_exc_q <= pwdata[fperr_pkg::STAT_SF_BIT] |
                             (instr_valid && exc_detect[fperr_pkg::EXC_INVALID] &&
                              exc_stack_fault);
      end else if (cmd_clr) begin
        flags_q           <= instr_valid ? exc_detect : 6'h00;
        stack_fault_exc_q <= instr_valid && exc_stack_fault &&
                             exc_detect[fperr_pkg::EXC_INVALID];
      end else if (instr_valid) begin
        flags_q           <= flags_q | exc_detect;
        stack_fault_exc_q <= stack_fault_exc_q |
                             (exc_detect[fperr_pkg::EXC_INVALID] && exc_stack_fault);
      end
    end
  end

  // ---------------------------------------------------------------
  // pending unmasked exception: captured from an instruction's unmasked exceptions
  // ---------------------------------------------------------------
  // captured when the exception is reported, so a later change of the
  // masks neither raises nor drops it; only a clear or a load does
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pending_q <= 1'b0;
    end else if (cmd_clr || ldenv_wr) begin
      pending_q <= instr_valid && (unmasked != 6'h00);
    end else if (instr_valid && (unmasked != 6'h00)) begin
      pending_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // error pin: immediate, legacy mode only, drops once cleared
  // ---------------------------------------------------------------
  // in native mode the pin stays low even with a pending exception; the
  // exception then goes straight to the handler instead
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fp_error_out <= 1'b0;
    end else if (native_error_enable_q) begin
      fp_error_out <= 1'b0;
    end else if (instr_valid && (unmasked != 6'h00)) begin
      fp_error_out <= 1'b1;
    end else begin
      fp_error_out <= pending_q && !cmd_clr && !ldenv_wr;
    end
  end

  // in legacy mode a waiting non-vector instruction freezes while an unmasked exception is pending and the ignore pin is low
  assign stall_now = instr_valid && !instr_nowait && !instr_vector && pending_q &&
                     !native_error_enable_q && !ignore_s;

  // ---------------------------------------------------------------
  // freeze state machine; interrupt accepted only with flag set
  // ---------------------------------------------------------------
  // the handler state lasts one cycle so that entry is a single pulse;
  // with the flag clear a frozen unit waits for as long as it takes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= fperr_pkg::FPERR_RUN;
    end else begin
      unique case (state_q)
        fperr_pkg::FPERR_RUN: begin
          if (stall_now) begin
            state_q <= fperr_pkg::FPERR_FROZEN;
          end
        end
        fperr_pkg::FPERR_FROZEN: begin
          // no-wait work never opens this window
          if (!pending_q) begin
            state_q <= fperr_pkg::FPERR_RUN;
          end else if (maskable_interrupt_in_s && if_flag_q) begin
            state_q <= fperr_pkg::FPERR_IRQ;
          end
        end
        fperr_pkg::FPERR_IRQ: begin
          state_q <= fperr_pkg::FPERR_RUN;
        end
        default: begin
          state_q <= fperr_pkg::FPERR_RUN;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // execution side outputs
  // ---------------------------------------------------------------
  // instruction results answer one edge after it is taken; stall and handler entry also follow the state, round_mode follows rnd_q
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      instr_stall   <= 1'b0;
      instr_abort   <= 1'b0;
      fixup_apply   <= 1'b0;
      result_denorm <= 1'b0;
      result_zero   <= 1'b0;
      round_mode    <= fperr_pkg::RND_RESET;
      vector_exc    <= 1'b0;
      handler_enter <= 1'b0;
    end else begin
      instr_stall   <= stall_now || (state_q == fperr_pkg::FPERR_FROZEN && pending_q);
      instr_abort   <= instr_valid && (unmasked != 6'h00);
      fixup_apply   <= instr_valid && (exc_detect != 6'h00) &&
                       ((exc_detect & ~mask_q) == 6'h00);
      result_denorm <= instr_valid && mask_q[fperr_pkg::EXC_UNDER] &&
                       tiny_result && !below_min_denorm;
      result_zero   <= instr_valid && mask_q[fperr_pkg::EXC_UNDER] &&
                       tiny_result && below_min_denorm;
      round_mode    <= rnd_q;
      vector_exc    <= instr_valid && instr_vector && ((exc_detect & ~mask_q) != 6'h00);
      handler_enter <= (state_q == fperr_pkg::FPERR_IRQ) ||
                       (native_error_enable_q && instr_valid && (unmasked != 6'h00));
    end
  end

  // ---------------------------------------------------------------
  // apb read data, one wait-free access
  // ---------------------------------------------------------------
  // read data is captured in the setup cycle and stands in the access cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (paddr)
        fperr_pkg::ADDR_CTRL:   prdata <= {18'h00000, if_flag_q, native_error_enable_q,
                                           2'h0, rnd_q, 2'h0, mask_q};
        fperr_pkg::ADDR_STATUS: prdata <= {24'h000000, fp_error_out, stack_fault_exc_q,
                                           flags_q};
        fperr_pkg::ADDR_STATE:  prdata <= {28'h0000000, ignore_s, maskable_interrupt_in_s, state_q};
        default:                prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ready in every access phase; unmapped addresses answer an error
  // no wait states: every transfer is one setup and one access cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(addr_hit(paddr, fperr_pkg::ADDR_CTRL) ||
                 addr_hit(paddr, fperr_pkg::ADDR_STATUS) ||
                 addr_hit(paddr, fperr_pkg::ADDR_CMD) ||
                 addr_hit(paddr, fperr_pkg::ADDR_STATE));
    end
  end

endmodule : fperr_unit
`default_nettype wire

// ==== verification/fperr_checker.sv ====
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------
// port checker
// ---------------------------------------------------------------
module fperr_checker (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        instr_valid,
  input wire logic        instr_nowait,
  input wire logic        instr_vector,
  input wire logic [5:0]  exc_detect,
  input wire logic        tiny_result,
  input wire logic        below_min_denorm,
  input wire logic        instr_stall,
  input wire logic        instr_abort,
  input wire logic        fixup_apply,
  input wire logic        result_denorm,
  input wire logic        result_zero,
  input wire logic        handler_enter,
  input wire logic        fp_error_out
);
  logic [5:0] mask_q;
  logic       ne_q;
  logic       if_q;
  logic       wr;
  logic       umx;
  logic       msk;

  // completed writes and exception kinds seen against shadow masks
  assign wr  = psel && penable && pwrite && pready;
  assign umx = instr_valid && |(exc_detect & ~mask_q);
  assign msk = instr_valid && |exc_detect && !umx;

  // shadow of control fields; reinit only restores the masks
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_q <= 6'h3F;
      ne_q   <= 1'b0;
      if_q   <= 1'b0;
    end else if (wr && paddr == fperr_pkg::ADDR_CTRL) begin
      mask_q <= pwdata[5:0];
      ne_q   <= pwdata[fperr_pkg::CTRL_NE_BIT];
      if_q   <= pwdata[fperr_pkg::CTRL_IF_BIT];
    end else if (wr && paddr == fperr_pkg::ADDR_CMD && pwdata[1]) begin
      mask_q <= 6'h3F;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // a clear command with no instruction racing it
  sequence clr_seq;
    wr && paddr == fperr_pkg::ADDR_CMD && pwdata[0] && !instr_valid;
  endsequence

  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  apb_err_a: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  reset_quiet_a: assert property (disable iff (1'b0) sys_rst |=> !fp_error_out && !instr_stall)
    else $error("outputs active after reset");
  err_immediate_a: assert property (umx && !instr_vector && !ne_q |=> fp_error_out)
    else $error("error pin late");
  native_quiet_a: assert property (ne_q && !fp_error_out |=> !fp_error_out)
    else $error("error pin in native mode");
  abort_unmasked_a: assert property (umx && !instr_vector |=> instr_abort)
    else $error("unmasked exception not aborted");
  fixup_masked_a: assert property (msk |=> fixup_apply && !instr_abort)
    else $error("masked exception without fix-up");
  masked_quiet_a: assert property (msk && !fp_error_out |=> !fp_error_out)
    else $error("masked exception raised error pin");
  vector_quiet_a: assert property (instr_valid && instr_vector && !fp_error_out |=> !fp_error_out)
    else $error("vector exception raised error pin");
  under_form_a: assert property (msk && exc_detect[4] && tiny_result |=>
    result_zero == $past(below_min_denorm) && result_denorm != $past(below_min_denorm))
    else $error("wrong underflow result form");
  clear_drop_a: assert property (clr_seq |-> ##[1:2] !fp_error_out)
    else $error("error pin held after clear");
  nowait_free_a: assert property (instr_valid && instr_nowait && !instr_stall |=> !instr_stall)
    else $error("no-wait instruction stalled");
  irq_gate_a: assert property (handler_enter |-> if_q)
    else $error("interrupt taken with flag clear");
endmodule : fperr_checker

bind fperr_unit fperr_checker u_fperr_checker (
  .clk              (clk),              .sys_rst       (sys_rst),
  .psel             (psel),             .penable       (penable),
  .pwrite           (pwrite),           .paddr         (paddr),
  .pwdata           (pwdata),           .pready        (pready),
  .pslverr          (pslverr),          .instr_valid   (instr_valid),
  .instr_nowait     (instr_nowait),     .instr_vector  (instr_vector),
  .exc_detect       (exc_detect),       .tiny_result   (tiny_result),
  .below_min_denorm (below_min_denorm), .instr_stall   (instr_stall),
  .instr_abort      (instr_abort),      .fixup_apply   (fixup_apply),
  .result_denorm    (result_denorm),    .result_zero   (result_zero),
  .handler_enter    (handler_enter),    .fp_error_out  (fp_error_out)
);

`default_nettype wire

// ==== verification/fperr_irq_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------
// request and ignore latches beside the unit
// ---------------------------------------------------------------
module fperr_irq_model #(
  parameter int unsigned DLY = 3
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic fp_error_out,
  input  wire logic port_access,
  output var  logic maskable_interrupt_in,
  output var  logic ignore_numeric_error_in
);
  logic [7:0] dly_q;

  // board delay line; the latch catches a rising edge only, so a
  // port access really drops the request while the error stays up
  always_ff @(posedge clk) begin
    dly_q <= sys_rst ? 8'h00 : {dly_q[6:0], fp_error_out};
  end

  // request latch
  always_ff @(posedge clk) begin
    if (sys_rst || port_access) maskable_interrupt_in <= 1'b0;
    else if (dly_q[DLY-1] && !dly_q[DLY]) maskable_interrupt_in <= 1'b1;
  end

  // ignore latch, held clear by a low error pin
  always_ff @(posedge clk) begin
    if (sys_rst || !fp_error_out) ignore_numeric_error_in <= 1'b0;
    else if (port_access) ignore_numeric_error_in <= 1'b1;
  end
endmodule : fperr_irq_model

`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        instr_valid = 1'b0;
  logic        instr_nowait = 1'b0;
  logic        instr_vector = 1'b0;
  logic [5:0]  exc_detect = 6'h00;
  logic        exc_stack_fault = 1'b0;
  logic        tiny_result = 1'b0;
  logic        below_min_denorm = 1'b0;
  logic        port_access = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, instr_stall, instr_abort, fixup_apply;
  logic        result_denorm, result_zero, vector_exc, handler_enter;
  logic        ignore_numeric_error_in, maskable_interrupt_in, fp_error_out;
  logic [1:0]  round_mode;
  logic [31:0] rd;
  logic        serr;
  logic [5:0]  res;
  int          n_errors = 0;
  int          checks = 0;
  int          n_hand = 0;
  int          cmds[3] = '{fperr_pkg::CMD_CLEAR, fperr_pkg::CMD_REINIT, fperr_pkg::CMD_SAVE};

  fperr_unit u_fperr_unit (
    .clk (clk), .sys_rst (sys_rst), .psel (psel), .penable (penable), .pwrite (pwrite),
    .paddr (paddr), .pwdata (pwdata), .prdata (prdata), .pready (pready),
    .pslverr (pslverr), .instr_valid (instr_valid), .instr_nowait (instr_nowait),
    .instr_vector (instr_vector), .exc_detect (exc_detect),
    .exc_stack_fault (exc_stack_fault), .tiny_result (tiny_result),
    .below_min_denorm (below_min_denorm), .instr_stall (instr_stall),
    .instr_abort (instr_abort), .fixup_apply (fixup_apply),
    .result_denorm (result_denorm), .result_zero (result_zero),
    .round_mode (round_mode), .vector_exc (vector_exc), .handler_enter (handler_enter),
    .ignore_numeric_error_in (ignore_numeric_error_in),
    .maskable_interrupt_in (maskable_interrupt_in), .fp_error_out (fp_error_out)
  );
  fperr_irq_model u_fperr_irq_model (
    .clk (clk), .sys_rst (sys_rst), .fp_error_out (fp_error_out),
    .port_access (port_access), .maskable_interrupt_in (maskable_interrupt_in),
    .ignore_numeric_error_in (ignore_numeric_error_in)
  );

  // clock, and a count of handler entries so no pulse is missed
  always #50 clk = ~clk;
  always @(negedge clk) if (handler_enter === 1'b1) n_hand++;

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  // one transfer; the request stands until the rising edge that sees
  // pready high, and read data and error are taken at that same edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    cmp(pready, 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one instruction; results stand one cycle after it is taken
  task automatic fpi(input logic nw, input logic vec, input logic [5:0] e, input logic bm);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_nowait <= nw;
    instr_vector <= vec;
    exc_detect <= e;
    exc_stack_fault <= e[0];
    tiny_result <= e[4];
    below_min_denorm <= bm;
    @(posedge clk);
    instr_valid <= 1'b0;
    @(negedge clk);
    res = {vector_exc, result_zero, result_denorm, fixup_apply, instr_abort, fp_error_out};
  endtask : fpi

  task automatic pulse_port;
    @(posedge clk);
    port_access <= 1'b1;
    @(posedge clk);
    port_access <= 1'b0;
  endtask : pulse_port

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    apb(0, fperr_pkg::ADDR_CTRL, 0);
    cmp(rd, 32'h3F);
    apb(0, fperr_pkg::ADDR_STATUS, 0);
    cmp(rd, 32'h0);
    $display("test reset done");
    fpi(0, 0, 6'h12, 0);
    cmp(res, 6'h0C);
    fpi(0, 0, 6'h10, 1);
    cmp(res, 6'h14);
    fpi(0, 0, 6'h00, 0);
    apb(0, fperr_pkg::ADDR_STATUS, 0);
    cmp(rd[5:0], 6'h12);
    // every clearing path, then an environment load
    foreach (cmds[i]) begin
      fpi(0, 0, 6'h3F, 0);
      apb(1, fperr_pkg::ADDR_CMD, 32'h1 << cmds[i]);
      apb(0, fperr_pkg::ADDR_STATUS, 0);
      cmp(rd[5:0], 6'h00);
    end
    apb(1, fperr_pkg::ADDR_STATUS, 32'h2D);
    apb(0, fperr_pkg::ADDR_STATUS, 0);
    cmp(rd[5:0], 6'h2D);
    $display("test masked done");
    for (int r = 0; r < 4; r++) begin
      apb(1, fperr_pkg::ADDR_CTRL, (r << fperr_pkg::CTRL_RND_LSB) | 32'h3F);
      repeat (2) @(negedge clk);
      cmp(round_mode, r[1:0]);
    end
    apb(0, 8'h10, 0);
    cmp({serr, rd[30:0]}, 32'h80000000);
    apb(1, 8'h10, 0);
    cmp(serr, 1'b1);
    apb(0, fperr_pkg::ADDR_CTRL, 0);
    cmp(rd, 32'h33F);
    $display("test rounding done");
    // unmasked invalid, freeze with the interrupt flag clear, then set
    apb(1, fperr_pkg::ADDR_CTRL, 32'h3E);
    apb(1, fperr_pkg::ADDR_CMD, 32'h1);
    fpi(0, 0, 6'h01, 0);
    cmp(res, 6'h03);
    apb(0, fperr_pkg::ADDR_STATUS, 0);
    cmp(rd[7:0], 8'hC1);
    fpi(1, 0, 6'h00, 0);
    cmp(instr_stall, 1'b0);
    repeat (10) @(negedge clk);
    fpi(0, 0, 6'h00, 0);
    cmp(instr_stall, 1'b1);
    repeat (20) @(negedge clk);
    cmp(n_hand, 0);
    apb(0, fperr_pkg::ADDR_STATE, 0);
    cmp(rd, 32'h5);
    apb(1, fperr_pkg::ADDR_CTRL, 32'h203E);
    repeat (20) @(negedge clk);
    cmp(n_hand > 0, 1'b1);
    pulse_port();
    apb(1, fperr_pkg::ADDR_CMD, 32'h1);
    repeat (3) @(negedge clk);
    cmp({instr_stall, fp_error_out}, 2'b00);
    $display("test freeze done");
    // ignore input lets a waiting instruction through
    fpi(0, 0, 6'h01, 0);
    repeat (6) @(negedge clk);
    pulse_port();
    repeat (8) @(negedge clk);
    fpi(0, 0, 6'h00, 0);
    cmp(instr_stall, 1'b0);
    apb(1, fperr_pkg::ADDR_CMD, 32'h1);
    fpi(0, 1, 6'h01, 0);
    cmp(res[0], 1'b0);
    cmp(res[5], 1'b1);
    apb(1, fperr_pkg::ADDR_CTRL, 32'h303E);
    fpi(0, 0, 6'h01, 0);
    cmp(res[0], 1'b0);
    $display("test ignore done");
    complete_run();
  end

  // watchdog, well past the expected few hundred cycles
  initial begin
    #2000000;
    n_errors++;
    complete_run();
  end
endmodule : tb

`default_nettype wire
